// ==== design/deser_status_regs.sv ====
// Shared configuration and status register bank of the deserializer
`timescale 1ns/10ps
module deser_status_regs #(
  parameter int unsigned STEP_CYCLES = deser_status_pkg::WDOG_STEP_CYCLES,
  // Revision code; the default value is arbitrary
  parameter logic [3:0] SILICON_REV = 4'hA
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input deser_status_pkg::reg_req_s regReq,
  output deser_status_pkg::reg_rsp_s regRsp,
  input wire logic initDone,
  input wire logic fuseChecksumOk,
  input wire logic passPin,
  input wire logic lockPin,
  input wire logic [deser_status_pkg::NUM_RX_PORTS-1:0] parityErrPulse,
  input wire logic [deser_status_pkg::NUM_RX_PORTS-1:0] parityCountClear,
  input wire logic ccTxnStart,
  input wire logic ccTxnDone,
  output logic parityCheckEn,
  output logic [deser_status_pkg::NUM_RX_PORTS-1:0] parityFault,
  output logic ccTxnAbort,
  output logic remoteWriteBlock
);
  import deser_status_pkg::*;

  typedef logic [NUM_RX_PORTS-1:0][PAR_CNT_W-1:0] port_cnt_t;

  typedef struct packed {
    logic [1:0] passSync;
    logic [1:0] lockSync;
    logic [1:0] genCfg;
    logic [7:0] parUpper;
    logic [7:0] parLower;
    logic [WDOG_FIELD_W-1:0] wdogTime;
    logic wdogOff;
    logic remoteBlock;
    logic [6:0] busCtl1Low;
    logic initSeen;
    logic cksumOk;
    logic passLatch;
    logic lockLatch;
    port_cnt_t parCount;
    logic [NUM_RX_PORTS-1:0] parFault;
    logic abortOut;
    reg_rsp_s rsp;
  } bank_s;

  bank_s q;
  bank_s d;

  logic [PAR_CNT_W-1:0] parLimit;
  port_cnt_t cntNext;
  logic [NUM_RX_PORTS-1:0] faultNext;
  logic wdAbort;
  logic doWrite;
  logic remoteRefused;
  logic condRead;
  logic [7:0] rdMux;

  // Threshold is the two byte registers side by side
  assign parLimit = {q.parUpper, q.parLower};

  // Per-port error counters; a clear and an error together give one
  for (genvar p = 0; p < NUM_RX_PORTS; p++) begin : g_port
    logic countIt;
    logic [PAR_CNT_W-1:0] base;
    assign countIt = parityErrPulse[p] && q.genCfg[GEN_PARITY_EN_BIT]
                     && (q.parCount[p] != {PAR_CNT_W{1'b1}});
    assign base = parityCountClear[p] ? '0 : q.parCount[p];
    assign cntNext[p] = base + {{(PAR_CNT_W-1){1'b0}}, countIt};
    assign faultNext[p] = (cntNext[p] >= parLimit);
  end

  // Remote writes refused while blocked; remote reads still answered
  assign remoteRefused = regReq.valid && regReq.write && regReq.remote
                         && q.remoteBlock;
  assign doWrite = regReq.valid && regReq.write && !remoteRefused;
  assign condRead = regReq.valid && !regReq.write
                    && (regReq.addr == ADDR_DEV_COND);

  // Read data selection; unmapped offsets read as zero
  always_comb begin
    rdMux = UNMAPPED_READ;
    unique case (regReq.addr)
      ADDR_GEN_CFG: rdMux = {6'h00, q.genCfg};
      ADDR_REVISION: rdMux = {SILICON_REV, 4'h0};
      ADDR_DEV_COND: begin
        rdMux[COND_CKSUM_BIT] = q.cksumOk;
        rdMux[COND_INIT_BIT] = q.initSeen;
        rdMux[COND_PASS_BIT] = q.passLatch;
        rdMux[COND_LOCK_BIT] = q.lockLatch;
      end
      ADDR_PAR_UPPER: rdMux = q.parUpper;
      ADDR_PAR_LOWER: rdMux = q.parLower;
      ADDR_WDOG: rdMux = {q.wdogTime, q.wdogOff};
      ADDR_BUS_CTL1: rdMux = {q.remoteBlock, q.busCtl1Low};
      default: rdMux = UNMAPPED_READ;
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    d = q;

    // Pins pass two flops before anything looks at them
    d.passSync = {q.passSync[0], passPin};
    d.lockSync = {q.lockSync[0], lockPin};

    // Register writes; read-only offsets silently ignore data
    if (doWrite) begin
      unique case (regReq.addr)
        ADDR_GEN_CFG: d.genCfg = regReq.wdata[1:0];
        ADDR_PAR_UPPER: d.parUpper = regReq.wdata;
        ADDR_PAR_LOWER: d.parLower = regReq.wdata;
        ADDR_WDOG: begin
          d.wdogTime = regReq.wdata[WDOG_TIME_MSB:WDOG_TIME_LSB];
          d.wdogOff = regReq.wdata[WDOG_OFF_BIT];
        end
        ADDR_BUS_CTL1: begin
          d.remoteBlock = regReq.wdata[BUS_REMOTE_BLOCK_BIT];
          d.busCtl1Low = regReq.wdata[6:0];
        end
        default: d.remoteBlock = q.remoteBlock;
      endcase
    end

    // Init status sticks; checksum sampled on the cycle init completes
    if (initDone && !q.initSeen) begin
      d.initSeen = 1'b1;
      d.cksumOk = fuseChecksumOk;
    end

    // Latched-high bits: a read clears, but a live pin sets again
    d.passLatch = (condRead ? 1'b0 : q.passLatch)
                  | q.passSync[1];
    d.lockLatch = (condRead ? 1'b0 : q.lockLatch)
                  | q.lockSync[1];

    // Parity counters and fault flags
    d.parCount = cntNext;
    d.parFault = faultNext;

    // Watchdog abort leaves through a flop
    d.abortOut = wdAbort;

    // One-cycle answer; reads show the value before this access
    d.rsp.rdValid = regReq.valid && !regReq.write;
    d.rsp.rdData = (regReq.valid && !regReq.write) ? rdMux : 8'h00;
    d.rsp.wrDone = doWrite;
    d.rsp.wrRejected = remoteRefused;
  end

  // State register; control bits come up at their documented values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.passSync <= 2'h0;
      q.lockSync <= 2'h0;
      q.genCfg <= GEN_CFG_RST;
      q.parUpper <= PAR_UPPER_RST;
      q.parLower <= PAR_LOWER_RST;
      q.wdogTime <= WDOG_TIME_RST;
      q.wdogOff <= WDOG_OFF_RST;
      q.remoteBlock <= BUS_REMOTE_BLOCK_RST;
      q.busCtl1Low <= BUS_CTL1_LOW_RST;
      q.initSeen <= 1'b0;
      q.cksumOk <= 1'b0;
      q.passLatch <= 1'b0;
      q.lockLatch <= 1'b0;
      q.parCount <= '0;
      q.parFault <= '0;
      q.abortOut <= 1'b0;
      q.rsp <= '0;
    end else begin
      q <= d;
    end
  end

  // Watchdog stops while the disable bit is set
  cc_watchdog #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_watchdog (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .runEnable(!q.wdogOff),
    .timeoutSteps(q.wdogTime),
    .txnStart(ccTxnStart),
    .txnDone(ccTxnDone),
    .txnAbort(wdAbort)
  );

  // Outputs straight from flops; the block bit only gates register
  // writes, never pass-through access to local-bus targets
  assign regRsp = q.rsp;
  assign parityCheckEn = q.genCfg[GEN_PARITY_EN_BIT];
  assign parityFault = q.parFault;
  assign ccTxnAbort = q.abortOut;
  assign remoteWriteBlock = q.remoteBlock;

endmodule // deser_status_regs

// ==== design/deser_status_pkg.sv ====
// Shared constants and carrier types for the deserializer status bank
// Functional notes
// - Forward-link parity checking runs while the enable bit is 1, is skipped at 0, and the bit resets to 1.
// - After initialization, status bit 7 is set only when the loaded fuse configuration had a valid checksum.
// - Status bit 6 is set once power-up initialization, fuse loading included, has finished.
// - Status bit 3 is a latched copy of the pass/fail test pin.
// - Status bit 2 is a latched copy of the link-acquired pin.
// - The 16-bit parity threshold takes its upper byte from 0x05 (reset 0x01) and its lower byte from 0x06 (reset 0x00).
// - Each receive port raises its parity fault once its error count reaches or passes the threshold.
// - A control-channel transaction not finished within the 7-bit timeout at bits 7:1, in 2 ms steps, reset 0x7F, is aborted.
// - The watchdog is stopped while disable bit 0 is 1, runs while it is 0, and the bit resets to 0.
// - While bit 7 of the first bus control register is 1, register writes arriving over the control channel are rejected.
// - The remote-write block leaves remote access to targets on the local bus untouched.
package deser_status_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_GEN_CFG = 8'h02;
  localparam logic [7:0] ADDR_REVISION = 8'h03;
  localparam logic [7:0] ADDR_DEV_COND = 8'h04;
  localparam logic [7:0] ADDR_PAR_UPPER = 8'h05;
  localparam logic [7:0] ADDR_PAR_LOWER = 8'h06;
  localparam logic [7:0] ADDR_WDOG = 8'h07;
  localparam logic [7:0] ADDR_BUS_CTL1 = 8'h08;

  // Field positions
  localparam int GEN_PARITY_EN_BIT = 1;
  localparam int COND_CKSUM_BIT = 7;
  localparam int COND_INIT_BIT = 6;
  localparam int COND_PASS_BIT = 3;
  localparam int COND_LOCK_BIT = 2;
  localparam int WDOG_OFF_BIT = 0;
  localparam int WDOG_TIME_LSB = 1;
  localparam int WDOG_TIME_MSB = 7;
  localparam int BUS_REMOTE_BLOCK_BIT = 7;
  localparam int REV_FIELD_LSB = 4;

  // Widths
  localparam int NUM_RX_PORTS = 2;
  localparam int PAR_CNT_W = 16;
  localparam int WDOG_FIELD_W = 7;

  // Reset values
  localparam logic [1:0] GEN_CFG_RST = 2'h2;
  localparam logic [7:0] PAR_UPPER_RST = 8'h01;
  localparam logic [7:0] PAR_LOWER_RST = 8'h00;
  localparam logic [6:0] WDOG_TIME_RST = 7'h7F;
  localparam logic WDOG_OFF_RST = 1'b0;
  localparam logic BUS_REMOTE_BLOCK_RST = 1'b0;
  localparam logic [6:0] BUS_CTL1_LOW_RST = 7'h1C;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Timing: watchdog step length and the clock it is counted on
  localparam int WDOG_STEP_MS = 2;
  localparam int SYS_CLK_MHZ = 200;
  localparam int WDOG_STEP_CYCLES = WDOG_STEP_MS * SYS_CLK_MHZ * 1000;
  localparam int TICK_W = 32;

  // Register access from the local bus target or the control channel
  typedef struct packed {
    logic valid;
    logic write;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // One-cycle answer to a register access
  typedef struct packed {
    logic rdValid;
    logic [7:0] rdData;
    logic wrDone;
    logic wrRejected;
  } reg_rsp_s;

endpackage

// ==== design/cc_watchdog.sv ====
// Control-channel transaction watchdog counted in fixed-length steps
`timescale 1ns/10ps
module cc_watchdog #(
  parameter int unsigned STEP_CYCLES = deser_status_pkg::WDOG_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic runEnable,
  input wire logic [deser_status_pkg::WDOG_FIELD_W-1:0] timeoutSteps,
  input wire logic txnStart,
  input wire logic txnDone,
  output logic txnAbort
);
  import deser_status_pkg::*;

  typedef enum logic {WD_IDLE, WD_RUN} wd_state_e;

  typedef struct packed {
    wd_state_e st;
    logic [TICK_W-1:0] tick;
    logic [WDOG_FIELD_W-1:0] steps;
    logic abort;
  } wd_s;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES - 1);

  wd_s q;
  wd_s d;

  // Prescaled step counter; a zero field would abort after one step
  always_comb begin
    d = q;
    d.abort = 1'b0;
    unique case (q.st)
      WD_IDLE: begin
        if (txnStart && runEnable) begin
          d.st = WD_RUN;
          d.tick = '0;
          d.steps = '0;
        end
      end
      WD_RUN: begin
        if (!runEnable || txnDone) begin
          d.st = WD_IDLE;
        end else if (q.tick == TICK_LAST) begin
          d.tick = '0;
          if (q.steps + 7'h01 >= timeoutSteps) begin
            d.abort = 1'b1;
            d.st = WD_IDLE;
          end else begin
            d.steps = q.steps + 7'h01;
          end
        end else begin
          d.tick = q.tick + 32'h1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: WD_IDLE, tick: '0, steps: '0, abort: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign txnAbort = q.abort;

endmodule // cc_watchdog

// ==== dv/fuse_loader_model.sv ====
// Behavioural fuse loader that finishes power-up init after a delay
`timescale 1ns/10ps
module fuse_loader_model #(
  parameter int LOAD_CYCLES = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic checksumGood,
  output logic initDone,
  output logic fuseChecksumOk
);
  int cnt;
  // Done is a level that stays up, checksum held valid beside it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      initDone <= 1'b0;
      fuseChecksumOk <= 1'b0;
    end else if (cnt < LOAD_CYCLES) begin
      cnt <= cnt + 1;
      fuseChecksumOk <= ~fuseChecksumOk; // Junk until load ends
    end else begin
      initDone <= 1'b1;
      fuseChecksumOk <= checksumGood;
    end
  end
endmodule // fuse_loader_model

// ==== dv/deser_status_regs_asserts.sv ====
// Register protocol checks for the status bank
`timescale 1ns/10ps
module deser_status_regs_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input deser_status_pkg::reg_req_s regReq,
  input deser_status_pkg::reg_rsp_s regRsp,
  input wire logic parityCheckEn,
  input wire logic ccTxnAbort,
  input wire logic remoteWriteBlock
);
  import deser_status_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write that the block lets through versus one it must refuse
  sequence okWr;
    regReq.valid && regReq.write && !(regReq.remote && remoteWriteBlock);
  endsequence
  sequence blockedWr;
    regReq.valid && regReq.write && regReq.remote && remoteWriteBlock;
  endsequence
  a_read_answer: assert property (
    regReq.valid && !regReq.write |=> regRsp.rdValid && !regRsp.wrDone)
    else $error("read not answered");
  a_write_answer: assert property (
    okWr |=> regRsp.wrDone && !regRsp.wrRejected)
    else $error("write not applied");
  a_remote_reject: assert property (
    blockedWr |=> regRsp.wrRejected && !regRsp.wrDone)
    else $error("remote write not refused");
  a_rd_zero: assert property (!regRsp.rdValid |-> regRsp.rdData == 8'h00)
    else $error("read data outside answer");
  a_block_follow: assert property (
    okWr and regReq.addr == ADDR_BUS_CTL1 |=> remoteWriteBlock == $past(
    regReq.wdata[7])) else $error("remote block bit wrong");
  a_enable_follow: assert property (
    okWr and regReq.addr == ADDR_GEN_CFG |=> parityCheckEn == $past(
    regReq.wdata[1])) else $error("parity enable wrong");
  a_block_hold: assert property (
    !(regReq.valid && regReq.addr == ADDR_BUS_CTL1) |=>
    $stable(remoteWriteBlock)) else $error("remote block moved");
  a_abort_single: assert property (ccTxnAbort |=> !ccTxnAbort)
    else $error("abort longer than one cycle");
endmodule // deser_status_regs_asserts
bind deser_status_regs deser_status_regs_asserts u_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
  .parityCheckEn(parityCheckEn), .ccTxnAbort(ccTxnAbort),
  .remoteWriteBlock(remoteWriteBlock));

// ==== dv/tb_deserializer_shared_status_regs.sv ====
// Self-checking bench for the deserializer status register bank
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_deserializer_shared_status_regs;
  import deser_status_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, passPin = 1'b0, lockPin = 1'b0;
  logic ccTxnStart = 1'b0, ccTxnDone = 1'b0, initDone, fuseChecksumOk;
  logic [1:0] parityErrPulse = 2'h0, parityCountClear = 2'h0;
  logic parityCheckEn, ccTxnAbort, remoteWriteBlock;
  logic [1:0] parityFault;
  reg_req_s regReq = '0;
  reg_rsp_s regRsp, rsp;
  int fails = 0, checked = 0;
  logic seen;
  // Checksum outcome the fuse loader reports after the next reset
  logic cksumGood = 1'b1;
  fuse_loader_model u_fuse (.sys_clk(sys_clk), .rst_n(rst_n),
    .checksumGood(cksumGood), .initDone(initDone),
    .fuseChecksumOk(fuseChecksumOk));
  deser_status_regs #(.STEP_CYCLES(4)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp), .initDone(initDone),
    .fuseChecksumOk(fuseChecksumOk), .passPin(passPin), .lockPin(lockPin),
    .parityErrPulse(parityErrPulse), .parityCountClear(parityCountClear),
    .ccTxnStart(ccTxnStart), .ccTxnDone(ccTxnDone),
    .parityCheckEn(parityCheckEn), .parityFault(parityFault),
    .ccTxnAbort(ccTxnAbort), .remoteWriteBlock(remoteWriteBlock));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One access: held across its taking edge; the answer stands for one
  // cycle only, so it is taken at the very next falling edge
  task automatic acc(input logic wr, rem, input logic [7:0] a, d);
    @(negedge sys_clk);
    regReq = '{1'b1, wr, rem, a, d};
    @(negedge sys_clk);
    rsp = regRsp;
    regReq = '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(1'b0, 1'b0, a, 8'h00);
    `CHK(rsp.rdData, e)
  endtask
  // Abort watch over a bounded window; no wait runs open-ended
  task automatic watchAbort(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge sys_clk);
      seen |= ccTxnAbort;
    end
  endtask
  task automatic pulseErr(input int n);
    repeat (n) begin
      @(negedge sys_clk) parityErrPulse = 2'h1;
      @(negedge sys_clk) parityErrPulse = 2'h0;
    end
    @(negedge sys_clk);
  endtask
  task automatic t_reset();
    `CHK(parityCheckEn, 1'b1)
    rd(ADDR_GEN_CFG, 8'h02);
    rd(ADDR_PAR_UPPER, 8'h01);
    rd(ADDR_PAR_LOWER, 8'h00);
    rd(ADDR_WDOG, 8'hFE);
    rd(ADDR_BUS_CTL1, 8'h1C);
  endtask
  task automatic t_status();
    repeat (10) @(negedge sys_clk);
    rd(ADDR_DEV_COND, 8'hC0);
    passPin = 1'b1;
    lockPin = 1'b1;
    repeat (2) @(negedge sys_clk);
    passPin = 1'b0;
    lockPin = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(ADDR_DEV_COND, 8'hCC);
    rd(ADDR_DEV_COND, 8'hC0);
  endtask
  task automatic t_parity();
    acc(1'b1, 1'b0, ADDR_PAR_UPPER, 8'h00);
    acc(1'b1, 1'b0, ADDR_PAR_LOWER, 8'h03);
    pulseErr(2);
    `CHK(parityFault, 2'h0)
    pulseErr(1);
    `CHK(parityFault, 2'h1)
    parityCountClear = 2'h3;
    @(negedge sys_clk) parityCountClear = 2'h0;
    acc(1'b1, 1'b0, ADDR_GEN_CFG, 8'h00);
    pulseErr(3);
    `CHK(parityFault, 2'h0)
    acc(1'b1, 1'b0, ADDR_GEN_CFG, 8'h02);
  endtask
  task automatic t_watchdog(input logic [7:0] cfg, input int doneAt,
                            input logic exp);
    acc(1'b1, 1'b0, ADDR_WDOG, cfg);
    @(negedge sys_clk) ccTxnStart = 1'b1;
    @(negedge sys_clk) ccTxnStart = 1'b0;
    if (doneAt > 0) begin
      repeat (doneAt) @(negedge sys_clk);
      ccTxnDone = 1'b1;
      @(negedge sys_clk) ccTxnDone = 1'b0;
    end
    watchAbort(30);
    `CHK(seen, exp)
  endtask
  task automatic t_remote();
    acc(1'b1, 1'b0, ADDR_BUS_CTL1, 8'h9C);
    `CHK(remoteWriteBlock, 1'b1)
    acc(1'b1, 1'b1, ADDR_PAR_UPPER, 8'hAA);
    `CHK(rsp.wrRejected, 1'b1)
    acc(1'b0, 1'b1, ADDR_PAR_UPPER, 8'h00);
    `CHK(rsp.rdData, 8'h00)
    acc(1'b0, 1'b1, ADDR_BUS_CTL1, 8'h00);
    `CHK(rsp.rdData, 8'h9C)
    rd(8'h40, UNMAPPED_READ);
    acc(1'b1, 1'b0, ADDR_BUS_CTL1, 8'h1C);
    acc(1'b1, 1'b1, ADDR_PAR_UPPER, 8'h5A);
    `CHK(rsp.wrDone, 1'b1)
    rd(ADDR_PAR_UPPER, 8'h5A);
  endtask
  // Mid-run reset with a bad fuse checksum; status stays clear until init
  task automatic t_init();
    cksumGood = 1'b0;
    @(negedge sys_clk) rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(ADDR_DEV_COND, 8'h00);
    rd(ADDR_WDOG, 8'hFE);
    repeat (10) @(negedge sys_clk);
    rd(ADDR_DEV_COND, 8'h40);
  endtask
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_status();
    t_parity();
    t_watchdog(8'h02, 0, 1'b1);
    t_watchdog(8'h02, 1, 1'b0);
    t_watchdog(8'h03, 0, 1'b0);
    t_remote();
    t_init();
    final_report();
  end
endmodule // tb_deserializer_shared_status_regs
